/* File: src/pks_map.svh */
`ifndef PKS_MAP_SVH
`define PKS_MAP_SVH
// Command and report codes
`define PKS_CMD_ACK 8'h01
`define PKS_CMD_STATUS_REQ 8'h08
`define PKS_CMD_KEY_SER 8'h30
`define PKS_CMD_SER_DATA 8'h31
`define PKS_CMD_WHITELIST 8'h32
`define PKS_CMD_CERT 8'h58
`define PKS_CMD_RESET 8'hFF
`define PKS_RPT_STATE 8'h20
`define PKS_RPT_BB_HOST 8'h29
// Command argument values and whitelist report count
`define PKS_KEY_STRIPE 8'h00
`define PKS_CERT_SEL 8'h02
`define PKS_CERT_SUB 8'h01
`define PKS_SOFT_RESET 8'h00
`define PKS_WL_COUNT 8'h24
// Acknowledge status codes
`define PKS_ACK_OK 8'h00
`define PKS_ACK_FAIL 8'h01
`define PKS_ACK_TIMEOUT 8'h02
`define PKS_ACK_BAD_CMD 8'h03
// Report lengths in bytes
`define PKS_LEN_ACK 6'h02
`define PKS_LEN_SER 6'h1C
`define PKS_LEN_WL 6'h26
`define PKS_LEN_STATE 6'h06
`define PKS_LEN_BB 6'h01
// Byte offsets inside the serial number and whitelist reports
`define PKS_KEY_SER_OFS 2
`define PKS_DSN_OFS 12
`define PKS_PAD_OFS 20
`define PKS_MAC_OFS 24
`define PKS_WL_OFS 2
// Timing
`define PKS_CLK_HZ 40000000
`define PKS_SER_LIFE_S 60
`define PKS_SEC_S 1
`define PKS_DISP_ZERO_SECS 9'h100
`endif

/* File: src/pks_pkg.sv */
package pks_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    PKS_IDLE, PKS_RX, PKS_EXEC, PKS_WAIT_DEC, PKS_WAIT_CERT, PKS_SEND
  } pks_state_e;
  // Report kinds
  typedef enum logic [2:0] {
    PKS_R_NONE, PKS_R_ACK, PKS_R_SERIAL, PKS_R_WL, PKS_R_STATE, PKS_R_BB
  } pks_rpt_e;
endpackage

/* File: src/pks_handler.sv */
`include "pks_map.svh"
// Notes on behaviour
// - Set-mode serial command snapshots selected key
// - No valid key gives all-zero data block
// - Serial report: code, key, serials, pad, MAC
// - Reported key serial expires after one minute
// - Big block: length, MAC container, data, MAC
// - Data and MAC use variants of key
// - Display seconds 1-255, zero means 256
// - Decrypted data displayed until time elapses
// - Failed command aborts, error in acknowledge
// - Good certificate request yields big-block report
// - Reset command with zero restarts the device
// - Only state reports are sent unprompted as events
// - State report on request and on change
// - State report bytes one to five fields
// - Acknowledge first, result report afterwards; get-mode serial command sends its report alone
module pks_handler #(
  parameter logic [25:0] CYCLES_PER_SEC = 26'(`PKS_CLK_HZ * `PKS_SEC_S),
  parameter logic [31:0] SER_LIFE_CYCLES = 32'(64'(`PKS_SER_LIFE_S) * 64'(`PKS_CLK_HZ))
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_last,
  input wire logic cmd_get,
  output logic cmd_ready,
  output logic rpt_valid,
  output logic [7:0] rpt_byte,
  output logic rpt_last,
  input wire logic rpt_ready,
  input wire logic key_ok_in,
  input wire logic [79:0] key_serial_number_in,
  input wire logic [63:0] dev_serial_in,
  input wire logic [31:0] ser_mac_in,
  input wire logic [287:0] card_prefix_in,
  input wire logic [39:0] status_in,
  output logic decrypt_start,
  input wire logic decrypt_done,
  input wire logic decrypt_fail,
  output logic display_on,
  output logic cert_req,
  input wire logic cert_done,
  input wire logic cert_fail,
  output logic soft_reset_req
);
  // Refuse settings the timers cannot serve
  if (CYCLES_PER_SEC < 26'h2 || SER_LIFE_CYCLES == 32'h0) begin : g_chk
    $error("pks_handler: timing parameters out of range");
  end

  pks_pkg::pks_state_e state_reg, state_next; // Sequencer
  pks_pkg::pks_rpt_e kind_reg, kind_next; // Report on the wire
  pks_pkg::pks_rpt_e next_kind_reg, next_kind_next; // Queued result report
  logic [7:0] cmd_buf_reg [0:7]; // Command bytes
  logic [7:0] cmd_buf_next [0:7];
  logic [3:0] rx_cnt_reg, rx_cnt_next; // Bytes received
  logic get_reg, get_next; // Get-mode flag
  logic [5:0] idx_reg, idx_next; // Index of byte on the wire
  logic [7:0] status_reg, status_next; // Acknowledge status
  logic [79:0] key_ser_snap_reg, key_ser_snap_next; // Reported key serial
  logic [63:0] dsn_snap_reg, dsn_snap_next; // Device serial
  logic [31:0] mac_snap_reg, mac_snap_next; // Report MAC
  logic key_ok_reg, key_ok_next; // Key was valid at snapshot
  logic [287:0] wl_snap_reg, wl_snap_next; // Whitelist slots
  logic [39:0] st_snap_reg, st_snap_next; // State fields
  logic [39:0] last_status_reg, last_status_next; // For change detect
  logic pend_state_reg, pend_state_next; // State report owed
  logic [31:0] ser_left_reg, ser_left_next; // Validity countdown
  logic [25:0] disp_div_reg, disp_div_next; // Second prescaler
  logic [8:0] disp_secs_reg, disp_secs_next; // Seconds left on display
  logic display_on_reg, display_on_next;
  logic reset_pend_reg, reset_pend_next; // Restart after acknowledge
  logic decrypt_start_reg, decrypt_start_next;
  logic cert_req_reg, cert_req_next;
  logic soft_reset_reg, soft_reset_next;
  logic cmd_ready_reg, cmd_ready_next;
  logic rpt_valid_reg, rpt_valid_next;
  logic [7:0] rpt_byte_reg, rpt_byte_next;
  logic rpt_last_reg, rpt_last_next;

  // Report length per kind
  function automatic logic [5:0] rpt_len(pks_pkg::pks_rpt_e k);
    unique case (k)
      pks_pkg::PKS_R_ACK: return `PKS_LEN_ACK;
      pks_pkg::PKS_R_SERIAL: return `PKS_LEN_SER;
      pks_pkg::PKS_R_WL: return `PKS_LEN_WL;
      pks_pkg::PKS_R_STATE: return `PKS_LEN_STATE;
      pks_pkg::PKS_R_BB: return `PKS_LEN_BB;
      pks_pkg::PKS_R_NONE: return 6'h01;
    endcase
  endfunction

  // Byte k of an n-byte field, first byte most significant
  function automatic logic [7:0] field_byte(logic [287:0] v, int n, int k);
    return v[(n - 1 - k) * 8 +: 8];
  endfunction

  // Byte i of a report; byte zero is always the code
  function automatic logic [7:0] byte_at(pks_pkg::pks_rpt_e k, logic [5:0] i);
    int n;
    n = int'(i);
    unique case (k)
      pks_pkg::PKS_R_ACK: return (n == 0) ? `PKS_CMD_ACK : status_reg;
      pks_pkg::PKS_R_SERIAL: begin
        if (n == 0) return `PKS_CMD_KEY_SER;
        if (n == 1) return cmd_buf_reg[1];
        if (!key_ok_reg) return 8'h00;
        if (n < `PKS_DSN_OFS)
          return field_byte(288'(key_ser_snap_reg), 10, n - `PKS_KEY_SER_OFS);
        if (n < `PKS_PAD_OFS) return field_byte(288'(dsn_snap_reg), 8, n - `PKS_DSN_OFS);
        if (n < `PKS_MAC_OFS) return 8'h00;
        return field_byte(288'(mac_snap_reg), 4, n - `PKS_MAC_OFS);
      end
      pks_pkg::PKS_R_WL: begin
        if (n == 0) return `PKS_CMD_WHITELIST;
        if (n == 1) return `PKS_WL_COUNT;
        return field_byte(wl_snap_reg, 36, n - `PKS_WL_OFS);
      end
      pks_pkg::PKS_R_STATE: begin
        if (n == 0) return `PKS_RPT_STATE;
        return field_byte(288'(st_snap_reg), 5, n - 1);
      end
      pks_pkg::PKS_R_BB: return `PKS_RPT_BB_HOST;
      pks_pkg::PKS_R_NONE: return 8'h00;
    endcase
  endfunction

  // Next-state logic for the whole handler
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    next_kind_next = next_kind_reg;
    cmd_buf_next = cmd_buf_reg;
    rx_cnt_next = rx_cnt_reg;
    get_next = get_reg;
    idx_next = idx_reg;
    status_next = status_reg;
    key_ser_snap_next = key_ser_snap_reg;
    dsn_snap_next = dsn_snap_reg;
    mac_snap_next = mac_snap_reg;
    key_ok_next = key_ok_reg;
    wl_snap_next = wl_snap_reg;
    st_snap_next = st_snap_reg;
    last_status_next = status_in;
    pend_state_next = pend_state_reg;
    ser_left_next = (ser_left_reg != 32'h0) ? ser_left_reg - 32'h1 : 32'h0;
    disp_div_next = disp_div_reg;
    disp_secs_next = disp_secs_reg;
    display_on_next = display_on_reg;
    reset_pend_next = reset_pend_reg;
    decrypt_start_next = 1'b0;
    cert_req_next = 1'b0;
    soft_reset_next = 1'b0;
    rpt_valid_next = rpt_valid_reg;
    rpt_byte_next = rpt_byte_reg;
    // Display timer ticks once a second while lit
    if (display_on_reg) begin
      if (disp_div_reg == CYCLES_PER_SEC - 26'h1) begin
        disp_div_next = 26'h0;
        if (disp_secs_reg == 9'h1) display_on_next = 1'b0;
        disp_secs_next = disp_secs_reg - 9'h1;
      end else begin
        disp_div_next = disp_div_reg + 26'h1;
      end
    end
    unique case (state_reg)
      pks_pkg::PKS_IDLE: begin
        // Host command wins over an owed event report; none taken before ready
        if (cmd_valid && cmd_ready_reg) begin
          cmd_buf_next[0] = cmd_byte;
          get_next = cmd_get;
          rx_cnt_next = 4'h1;
          state_next = cmd_last ? pks_pkg::PKS_EXEC : pks_pkg::PKS_RX;
        end else if (pend_state_reg) begin
          kind_next = pks_pkg::PKS_R_STATE;
          next_kind_next = pks_pkg::PKS_R_NONE;
          st_snap_next = status_in;
          pend_state_next = 1'b0;
          idx_next = 6'h0;
          rpt_valid_next = 1'b1;
          rpt_byte_next = `PKS_RPT_STATE;
          state_next = pks_pkg::PKS_SEND;
        end
      end
      pks_pkg::PKS_RX: begin
        // Keep the first eight bytes, count stops at eight
        if (cmd_valid) begin
          if (rx_cnt_reg < 4'h8) cmd_buf_next[rx_cnt_reg[2:0]] = cmd_byte;
          if (rx_cnt_reg < 4'h8) rx_cnt_next = rx_cnt_reg + 4'h1;
          if (cmd_last) state_next = pks_pkg::PKS_EXEC;
        end
      end
      pks_pkg::PKS_EXEC: begin
        // Default answer: acknowledge with bad command
        status_next = `PKS_ACK_BAD_CMD;
        kind_next = pks_pkg::PKS_R_ACK;
        next_kind_next = pks_pkg::PKS_R_NONE;
        state_next = pks_pkg::PKS_SEND;
        unique case (cmd_buf_reg[0])
          `PKS_CMD_KEY_SER: begin
            if (get_reg) begin
              kind_next = pks_pkg::PKS_R_SERIAL;
            end else if (cmd_buf_reg[1] == `PKS_KEY_STRIPE) begin
              key_ser_snap_next = key_serial_number_in;
              dsn_snap_next = dev_serial_in;
              mac_snap_next = ser_mac_in;
              key_ok_next = key_ok_in;
              ser_left_next = key_ok_in ? SER_LIFE_CYCLES : 32'h0;
              status_next = `PKS_ACK_OK;
            end else begin
              status_next = `PKS_ACK_FAIL;
            end
          end
          `PKS_CMD_SER_DATA: begin
            if (ser_left_reg == 32'h0) begin
              status_next = `PKS_ACK_TIMEOUT;
            end else begin
              // Engine decrypts the stored big block under the key variants
              decrypt_start_next = 1'b1;
              state_next = pks_pkg::PKS_WAIT_DEC;
            end
          end
          `PKS_CMD_WHITELIST: begin
            wl_snap_next = card_prefix_in;
            status_next = `PKS_ACK_OK;
            next_kind_next = pks_pkg::PKS_R_WL;
          end
          `PKS_CMD_STATUS_REQ: begin
            status_next = `PKS_ACK_OK;
            next_kind_next = pks_pkg::PKS_R_STATE;
          end
          `PKS_CMD_CERT: begin
            if (rx_cnt_reg >= 4'h7 && cmd_buf_reg[1] == `PKS_CERT_SEL
                && cmd_buf_reg[2] == `PKS_CERT_SUB && cmd_buf_reg[3] == 8'h00
                && cmd_buf_reg[4] == 8'h00 && cmd_buf_reg[5] == 8'h00
                && cmd_buf_reg[6] == 8'h00) begin
              cert_req_next = 1'b1;
              state_next = pks_pkg::PKS_WAIT_CERT;
            end else begin
              status_next = `PKS_ACK_FAIL;
            end
          end
          `PKS_CMD_RESET: begin
            status_next = (cmd_buf_reg[1] == `PKS_SOFT_RESET) ? `PKS_ACK_OK : `PKS_ACK_FAIL;
            reset_pend_next = (cmd_buf_reg[1] == `PKS_SOFT_RESET);
          end
          default: ;
        endcase
        if (state_next == pks_pkg::PKS_SEND) begin
          idx_next = 6'h0;
          rpt_valid_next = 1'b1;
          rpt_byte_next = byte_at(kind_next, 6'h0);
        end
      end
      pks_pkg::PKS_WAIT_DEC: begin
        // Acknowledge only once the outcome is known
        if (decrypt_done) begin
          status_next = decrypt_fail ? `PKS_ACK_FAIL : `PKS_ACK_OK;
          if (!decrypt_fail) begin
            display_on_next = 1'b1;
            disp_div_next = 26'h0;
            disp_secs_next = (cmd_buf_reg[1] == 8'h00) ? `PKS_DISP_ZERO_SECS
                                                       : {1'b0, cmd_buf_reg[1]};
          end
          kind_next = pks_pkg::PKS_R_ACK;
          idx_next = 6'h0;
          rpt_valid_next = 1'b1;
          rpt_byte_next = `PKS_CMD_ACK;
          state_next = pks_pkg::PKS_SEND;
        end
      end
      pks_pkg::PKS_WAIT_CERT: begin
        if (cert_done) begin
          status_next = cert_fail ? `PKS_ACK_FAIL : `PKS_ACK_OK;
          next_kind_next = cert_fail ? pks_pkg::PKS_R_NONE : pks_pkg::PKS_R_BB;
          kind_next = pks_pkg::PKS_R_ACK;
          idx_next = 6'h0;
          rpt_valid_next = 1'b1;
          rpt_byte_next = `PKS_CMD_ACK;
          state_next = pks_pkg::PKS_SEND;
        end
      end
      pks_pkg::PKS_SEND: begin
        // Advance one byte per accepted transfer
        if (rpt_ready) begin
          if (idx_reg + 6'h1 < rpt_len(kind_reg)) begin
            idx_next = idx_reg + 6'h1;
            rpt_byte_next = byte_at(kind_reg, idx_next);
          end else if (next_kind_reg != pks_pkg::PKS_R_NONE) begin
            kind_next = next_kind_reg;
            next_kind_next = pks_pkg::PKS_R_NONE;
            if (next_kind_reg == pks_pkg::PKS_R_STATE) st_snap_next = status_in;
            if (next_kind_reg == pks_pkg::PKS_R_STATE) pend_state_next = 1'b0;
            idx_next = 6'h0;
            rpt_byte_next = byte_at(next_kind_reg, 6'h0);
          end else begin
            rpt_valid_next = 1'b0;
            state_next = pks_pkg::PKS_IDLE;
            if (reset_pend_reg) begin
              soft_reset_next = 1'b1;
              reset_pend_next = 1'b0;
              ser_left_next = 32'h0;
              display_on_next = 1'b0;
              key_ok_next = 1'b0;
            end
          end
        end
      end
    endcase
    // A change seen in the same cycle as a clear still counts
    if (status_in != last_status_reg) pend_state_next = 1'b1;
    rpt_last_next = rpt_valid_next && (idx_next == rpt_len(kind_next) - 6'h1);
    cmd_ready_next = (state_next == pks_pkg::PKS_IDLE) || (state_next == pks_pkg::PKS_RX);
  end

  // State registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= pks_pkg::PKS_IDLE;
      kind_reg <= pks_pkg::PKS_R_NONE;
      next_kind_reg <= pks_pkg::PKS_R_NONE;
      for (int i = 0; i < 8; i++) cmd_buf_reg[i] <= 8'h00;
      rx_cnt_reg <= 4'h0;
      get_reg <= 1'b0;
      idx_reg <= 6'h0;
      status_reg <= `PKS_ACK_OK;
      key_ser_snap_reg <= 80'h0;
      dsn_snap_reg <= 64'h0;
      mac_snap_reg <= 32'h0;
      key_ok_reg <= 1'b0;
      wl_snap_reg <= 288'h0;
      st_snap_reg <= 40'h0;
      last_status_reg <= 40'h0;
      pend_state_reg <= 1'b0;
      ser_left_reg <= 32'h0;
      disp_div_reg <= 26'h0;
      disp_secs_reg <= 9'h0;
      display_on_reg <= 1'b0;
      reset_pend_reg <= 1'b0;
      decrypt_start_reg <= 1'b0;
      cert_req_reg <= 1'b0;
      soft_reset_reg <= 1'b0;
      cmd_ready_reg <= 1'b0;
      rpt_valid_reg <= 1'b0;
      rpt_byte_reg <= 8'h00;
      rpt_last_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      next_kind_reg <= next_kind_next;
      cmd_buf_reg <= cmd_buf_next;
      rx_cnt_reg <= rx_cnt_next;
      get_reg <= get_next;
      idx_reg <= idx_next;
      status_reg <= status_next;
      key_ser_snap_reg <= key_ser_snap_next;
      dsn_snap_reg <= dsn_snap_next;
      mac_snap_reg <= mac_snap_next;
      key_ok_reg <= key_ok_next;
      wl_snap_reg <= wl_snap_next;
      st_snap_reg <= st_snap_next;
      last_status_reg <= last_status_next;
      pend_state_reg <= pend_state_next;
      ser_left_reg <= ser_left_next;
      disp_div_reg <= disp_div_next;
      disp_secs_reg <= disp_secs_next;
      display_on_reg <= display_on_next;
      reset_pend_reg <= reset_pend_next;
      decrypt_start_reg <= decrypt_start_next;
      cert_req_reg <= cert_req_next;
      soft_reset_reg <= soft_reset_next;
      cmd_ready_reg <= cmd_ready_next;
      rpt_valid_reg <= rpt_valid_next;
      rpt_byte_reg <= rpt_byte_next;
      rpt_last_reg <= rpt_last_next;
    end
  end

  // Outputs straight from flops
  assign cmd_ready = cmd_ready_reg;
  assign rpt_valid = rpt_valid_reg;
  assign rpt_byte = rpt_byte_reg;
  assign rpt_last = rpt_last_reg;
  assign decrypt_start = decrypt_start_reg;
  assign display_on = display_on_reg;
  assign cert_req = cert_req_reg;
  assign soft_reset_req = soft_reset_reg;

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic exec_ser_set;
  assign exec_ser_set = state_reg == pks_pkg::PKS_EXEC && cmd_buf_reg[0] == `PKS_CMD_KEY_SER
                        && !get_reg && cmd_buf_reg[1] == `PKS_KEY_STRIPE;
  a_ser_zero_fill: assert property (rpt_valid_reg && kind_reg == pks_pkg::PKS_R_SERIAL
    && !key_ok_reg && idx_reg >= 6'h2 |-> rpt_byte_reg == 8'h00)
    else $error("serial data not zero without key");
  a_ser_report_shape: assert property (rpt_valid_reg && kind_reg == pks_pkg::PKS_R_SERIAL
    && idx_reg == 6'h0 |-> rpt_byte_reg == `PKS_CMD_KEY_SER
    ##[1:1000] (rpt_last_reg && idx_reg == 6'h1B))
    else $error("serial report shape wrong");
  a_ser_life_load: assert property (exec_ser_set && key_ok_in
    |=> ser_left_reg == SER_LIFE_CYCLES ##1 ser_left_reg == SER_LIFE_CYCLES - 32'h1)
    else $error("serial lifetime not loaded");
  a_late_reject: assert property (state_reg == pks_pkg::PKS_EXEC
    && cmd_buf_reg[0] == `PKS_CMD_SER_DATA && ser_left_reg == 32'h0
    |=> !decrypt_start_reg && status_reg == `PKS_ACK_TIMEOUT)
    else $error("late data command not refused");
  a_disp_time: assert property (state_reg == pks_pkg::PKS_WAIT_DEC && decrypt_done
    && !decrypt_fail && cmd_buf_reg[1] == 8'h00 |=> display_on_reg && disp_secs_reg == 9'h100)
    else $error("zero display time not 256");
  a_disp_hold: assert property (display_on_reg && disp_secs_reg > 9'h1 |=> display_on_reg)
    else $error("display dropped early");
  a_err_ack: assert property (rpt_valid_reg && kind_reg == pks_pkg::PKS_R_ACK
    && status_reg != `PKS_ACK_OK |-> next_kind_reg == pks_pkg::PKS_R_NONE)
    else $error("result queued after failed command");
  a_ack_first: assert property (state_reg == pks_pkg::PKS_EXEC
    && cmd_buf_reg[0] == `PKS_CMD_WHITELIST
    |=> kind_reg == pks_pkg::PKS_R_ACK && next_kind_reg == pks_pkg::PKS_R_WL)
    else $error("acknowledge not first");
  a_wl_count: assert property (rpt_valid_reg && kind_reg == pks_pkg::PKS_R_WL
    && idx_reg == 6'h1 |-> rpt_byte_reg == `PKS_WL_COUNT)
    else $error("whitelist count wrong");
  a_cert_report: assert property (state_reg == pks_pkg::PKS_WAIT_CERT && cert_done
    && !cert_fail |=> next_kind_reg == pks_pkg::PKS_R_BB)
    else $error("certificate report not queued");
  a_reset_clears: assert property (soft_reset_reg |-> ser_left_reg == 32'h0
    && !display_on_reg && $past(rpt_last_reg))
    else $error("restart state wrong");
  a_state_pend: assert property ($changed(status_in) |=> pend_state_reg)
    else $error("state change lost");
  a_state_fields: assert property (rpt_valid_reg && kind_reg == pks_pkg::PKS_R_STATE
    && idx_reg == 6'h1 |-> rpt_byte_reg == st_snap_reg[39:32])
    else $error("state byte one wrong");
  c_ser_report: cover property (rpt_valid_reg && kind_reg == pks_pkg::PKS_R_SERIAL && rpt_last_reg);
  c_display: cover property (display_on_reg ##1 !display_on_reg);
  c_cert: cover property (rpt_valid_reg && kind_reg == pks_pkg::PKS_R_BB);
  c_auto_state: cover property (state_reg == pks_pkg::PKS_IDLE && pend_state_reg && !cmd_valid);
endmodule

/* File: testbench/pks_host_model.sv */
// Host side of the report stream: accepts bytes with random stalls
module pks_host_model (
  input wire logic clk,
  input wire logic rpt_valid,
  input wire logic [7:0] rpt_byte,
  input wire logic rpt_last,
  output logic rpt_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$]; // Bytes taken so far
  logic lst[$]; // Last flags of those bytes
  logic [3:0] lfsr = 4'h9; // Stall pattern
  initial rpt_ready = 1'b0;
  // Ready changes off the sampling edge only
  always @(negedge clk) begin
    lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
    rpt_ready <= lfsr[0] | lfsr[1];
  end
  // Byte taken at the edge where valid and ready meet
  always @(posedge clk) begin
    if (rpt_valid && rpt_ready) begin
      got.push_back(rpt_byte);
      lst.push_back(rpt_last);
    end
  end
endmodule

/* File: testbench/test_pinpad_key_serial_command_handler.sv */
module test_pinpad_key_serial_command_handler;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, cmd_valid, cmd_last, cmd_get, cmd_ready, rpt_valid, rpt_last;
  logic rpt_ready, key_ok_in, decrypt_start, decrypt_done, decrypt_fail, display_on;
  logic cert_req, cert_done, cert_fail, soft_reset_req;
  logic [7:0] cmd_byte, rpt_byte;
  logic [79:0] key_serial_number_in;
  logic [63:0] dev_serial_in;
  logic [31:0] ser_mac_in, seed = 32'h000043FD;
  logic [287:0] card_prefix_in;
  logic [39:0] status_in;
  logic [7:0] exp_q[$]; // Expected report bytes
  logic exp_l[$]; // Expected last-byte flags
  int num_errors = 0, comparisons = 0, n, pb, pc[3];
  pks_handler #(.CYCLES_PER_SEC(26'h14), .SER_LIFE_CYCLES(32'h12C)) DUT (.clk, .sys_rst,
    .cmd_valid, .cmd_byte, .cmd_last, .cmd_get, .cmd_ready, .rpt_valid, .rpt_byte,
    .rpt_last, .rpt_ready, .key_ok_in, .key_serial_number_in, .dev_serial_in, .ser_mac_in,
    .card_prefix_in, .status_in, .decrypt_start, .decrypt_done, .decrypt_fail, .display_on,
    .cert_req, .cert_done, .cert_fail, .soft_reset_req);
  pks_host_model host (.clk, .rpt_valid, .rpt_byte, .rpt_last, .rpt_ready);
  // Clock at 25 ns
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // Count engine and restart pulses
  always @(posedge clk) begin
    pc[0] += int'(decrypt_start);
    pc[1] += int'(cert_req);
    pc[2] += int'(soft_reset_req);
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task results();
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  // One command frame, each byte held until taken
  task send(input logic [7:0] b[$], input logic g);
    for (int i = 0; i < b.size(); i++) begin
      @(negedge clk);
      {cmd_valid, cmd_byte, cmd_last, cmd_get} = {1'b1, b[i], i == b.size() - 1, g};
      n = 0;
      while (cmd_ready !== 1'b1 && n < 300) begin
        @(negedge clk);
        n++;
      end
    end
    @(negedge clk);
    {cmd_valid, cmd_last} = 2'h0;
  endtask
  // Queue bytes from the top of a left-aligned vector
  task px(input logic [287:0] v, input int nb);
    for (int i = 0; i < nb; i++) begin
      exp_q.push_back(v[287-8*i -: 8]);
      exp_l.push_back(i == nb - 1);
    end
  endtask
  task ack(input logic [7:0] s);
    px({8'h01, s, 272'h0}, 2);
  endtask
  // Compare everything the host took against the queue
  task expect_rpt(input string m);
    n = 0;
    while (host.got.size() < exp_q.size() && n < 500) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    for (int i = 0; i < exp_q.size(); i++) begin
      chk(i < host.got.size() ? host.got[i] : ~exp_q[i], exp_q[i], m);
      chk(i < host.lst.size() ? 8'(host.lst[i]) : 8'hFF, 8'(exp_l[i]), m);
    end
    chk(8'(host.got.size()), 8'(exp_q.size()), m);
    host.got.delete();
    host.lst.delete();
    exp_q.delete();
    exp_l.delete();
  endtask
  // Engine answers one pulse of request k
  task serve(input int k, input int p0);
    n = 0;
    while (pc[k] == p0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (k == 0) decrypt_done = 1;
    else cert_done = 1;
    @(negedge clk);
    {decrypt_done, cert_done} = 2'h0;
    chk(8'(pc[k] - p0), 8'h01, "pulse");
  endtask
  initial begin
    #(20000 * 25);
    num_errors++;
    results();
  end
  initial begin
    {cmd_valid, cmd_byte, cmd_last, cmd_get, key_ok_in, decrypt_done} = 13'h0;
    {decrypt_fail, cert_done, cert_fail, status_in} = 43'h0;
    key_serial_number_in = 80'({rnd(), rnd(), rnd()});
    dev_serial_in = {rnd(), rnd()};
    ser_mac_in = rnd();
    card_prefix_in = {9{rnd()}};
    sys_rst = 1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 0;
    repeat (2) @(negedge clk);
    // Unprompted state report on a status change
    status_in = 40'({rnd(), rnd()}) | 40'h1;
    px({8'h20, status_in, 240'h0}, 6);
    expect_rpt("auto state");
    send('{8'h08}, 0);
    ack(8'h00);
    px({8'h20, status_in, 240'h0}, 6);
    expect_rpt("state req");
    // Serial set then get with a valid key
    key_ok_in = 1;
    send('{8'h30, 8'h00}, 0);
    ack(8'h00);
    expect_rpt("serial set");
    send('{8'h30, 8'h00}, 1);
    px({8'h30, 8'h00, key_serial_number_in, dev_serial_in, 32'h0, ser_mac_in, 64'h0}, 28);
    expect_rpt("serial get");
    // Zero display time means 256 seconds
    send('{8'h31, 8'h00}, 0);
    serve(0, pc[0]);
    ack(8'h00);
    expect_rpt("decrypt");
    chk({7'h0, display_on}, 8'h01, "display on");
    repeat (256 * 20 - 70) @(negedge clk);
    chk({7'h0, display_on}, 8'h01, "display held");
    repeat (100) @(negedge clk);
    chk({7'h0, display_on}, 8'h00, "display off");
    // Serial validity long gone
    pb = pc[0];
    send('{8'h31, 8'h05}, 0);
    ack(8'h02);
    expect_rpt("expired");
    chk(8'(pc[0] - pb), 8'h00, "no start");
    // No key gives an all-zero block
    key_ok_in = 0;
    send('{8'h30, 8'h00}, 0);
    ack(8'h00);
    expect_rpt("serial set 2");
    send('{8'h30, 8'h00}, 1);
    px({8'h30, 8'h00, 272'h0}, 28);
    expect_rpt("serial zero");
    send('{8'h32}, 0);
    ack(8'h00);
    px({8'h32, 8'h24, 272'h0}, 2);
    exp_l[exp_l.size() - 1] = 1'b0;
    px(card_prefix_in, 36);
    expect_rpt("whitelist");
    send('{8'h58, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
    serve(1, pc[1]);
    ack(8'h00);
    px({8'h29, 280'h0}, 1);
    expect_rpt("cert");
    // Certificate source reports failure: error acknowledge, no big block
    cert_fail = 1;
    send('{8'h58, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
    serve(1, pc[1]);
    cert_fail = 0;
    ack(8'h01);
    expect_rpt("cert fail");
    // Unknown command code
    send('{8'h77}, 0);
    ack(8'h03);
    expect_rpt("unknown");
    send('{8'h58, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
    ack(8'h01);
    expect_rpt("cert bad");
    send('{8'hFF, 8'h01}, 0);
    ack(8'h01);
    expect_rpt("reset bad");
    pb = pc[2];
    send('{8'hFF, 8'h00}, 0);
    ack(8'h00);
    expect_rpt("reset");
    chk(8'(pc[2] - pb), 8'h01, "restart");
    results();
  end
endmodule
